// ---- logic/wdtrf_counter.sv ----
`timescale 1ns/10ps
module wdtrf_counter
  import wdtrf_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WDT_BASE_CYCLES
)
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // control
  input  wire logic       tick_in,     // one oscillator cycle seen
  input  wire logic       clear_in,    // restart request or reset event
  input  wire logic       run_in,      // mode is not stopped
  input  wire logic [3:0] select_in,   // prescale code
  // result
  output logic            timeout_out  // one-cycle pulse
);

  logic [WDT_CNT_W-1:0] count_r; // oscillator cycles since restart
  logic [WDT_CNT_W-1:0] last;    // final count of the period

  // last count for a code; reserved codes use the longest period
  function automatic logic [WDT_CNT_W-1:0] last_count(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > PS_MAX_CODE) ? PS_MAX_CODE : sel;
    return WDT_CNT_W'((BASE_CYCLES << s) - 1);
  endfunction : last_count

  assign last = last_count(select_in);

  // count oscillator edges; held at zero when stopped
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count_r     <= '0;
      timeout_out <= 1'b0;
    end
    else
    begin
      timeout_out <= 1'b0;
      if (clear_in || !run_in)
        count_r <= '0;
      else if (tick_in)
      begin
        // shrinking the period below the count fires on the next tick
        if (count_r >= last)
        begin
          count_r     <= '0;
          timeout_out <= 1'b1;
        end
        else
          count_r <= count_r + WDT_CNT_W'(1);
      end
    end
  end

endmodule : wdtrf_counter

// ---- logic/wdtrf_sync.sv ----
`timescale 1ns/10ps
module wdtrf_sync
  import wdtrf_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // asynchronous levels in, synchronised levels out
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  // per lane two flops; first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_lane
      logic meta_r; // first stage
      logic sync_r; // second stage
      always_ff @(posedge clock_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          meta_r <= SYNC_INIT[g];
          sync_r <= SYNC_INIT[g];
        end
        else
        begin
          meta_r <= async_in[g];
          sync_r <= meta_r;
        end
      end
      assign sync_out[g] = sync_r;
    end
  endgenerate

endmodule : wdtrf_sync

// ---- logic/wdtrf_top.sv ----
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module wdtrf_top
  import wdtrf_pkg::*;
#(
  parameter int unsigned TIMEOUT_BASE_CYCLES = WDT_BASE_CYCLES
)
(
  // clock and power-on reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [APB_AW-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // asynchronous pins
  input  wire logic              wdt_osc_in,
  input  wire logic              brownout_rst_in,
  input  wire logic              external_rst_in,
  input  wire logic              always_on_fuse_in,
  // core side, same clock
  input  wire logic              global_irq_enable_in,
  input  wire logic              irq_ack_in,
  input  wire logic              wdt_restart_in,
  // results
  output logic                   irq_out,
  output logic                   sys_reset_out
);

  // synchronised pins and edge history
  logic [SYNC_W-1:0] pin_sync;
  logic              osc_prev_r;
  logic              bo_prev_r;
  logic              ext_prev_r;
  logic              osc_tick;   // rising oscillator edge
  logic              bo_evt;     // brown-out reset began
  logic              ext_evt;    // external reset began
  logic              fuse_prog;  // fuse reads 0: programmed

  // control register state
  logic              irq_flag_r;
  logic              irq_en_r;
  logic [3:0]        ps_r;
  logic              ce_r;
  logic [1:0]        ce_cnt_r;
  logic              wde_r;
  // reset cause state
  logic              watchdog_reset_flag_r;
  logic              brownout_reset_flag_r;
  logic              external_reset_flag_r;
  logic              poweron_reset_flag_r;

  // derived
  logic              wde_eff;    // reset enable as seen by software
  logic              ie_eff;     // irq enable after fuse override
  wdtrf_mode_t       mode;
  logic              timeout;
  logic              set_flag;
  logic              wdt_fire;
  logic              sys_evt;    // any non power-on reset happened
  logic              acc;
  logic              setup;
  logic              wr;
  logic              wr_ctrl;
  logic              wr_cause;
  logic [7:0]        ctrl_rd;
  logic [7:0]        cause_rd;

  // pins cross into the core clock here
  wdtrf_sync u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({always_on_fuse_in, external_rst_in, brownout_rst_in, wdt_osc_in}),
    .sync_out   (pin_sync)
  );

  // edge history on synchronised levels only
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      osc_prev_r <= 1'b0;
      bo_prev_r  <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      osc_prev_r <= pin_sync[SYNC_OSC];
      bo_prev_r  <= pin_sync[SYNC_BO];
      ext_prev_r <= pin_sync[SYNC_EXT];
    end
  end

  assign osc_tick  = pin_sync[SYNC_OSC] & ~osc_prev_r;
  assign bo_evt    = pin_sync[SYNC_BO] & ~bo_prev_r;
  assign ext_evt   = pin_sync[SYNC_EXT] & ~ext_prev_r;
  assign fuse_prog = ~pin_sync[SYNC_FUSE];

  // overrides: cause flag and fuse pin the enables
  assign wde_eff = wde_r | watchdog_reset_flag_r | fuse_prog;
  assign ie_eff  = irq_en_r & ~fuse_prog;
  assign mode    = wdtrf_decode_mode(fuse_prog, wde_eff, ie_eff);

  // time-out action by mode; combined mode resets if flag still pending
  always_comb
  begin
    set_flag = 1'b0;
    wdt_fire = 1'b0;
    unique case (mode)
      WDTRF_STOP: ;
      WDTRF_IRQ:  set_flag = timeout;
      WDTRF_RST:  wdt_fire = timeout;
      WDTRF_BOTH:
      begin
        set_flag = timeout & ~irq_flag_r;
        wdt_fire = timeout & irq_flag_r;
      end
    endcase
  end

  assign sys_evt = sys_reset_out | bo_evt | ext_evt;

  // timer core; cleared by restart and by any system reset
  wdtrf_counter #(
    .BASE_CYCLES (TIMEOUT_BASE_CYCLES)
  ) u_counter (
    .clock_in    (clock_in),
    .sys_rst_in  (sys_rst_in),
    .tick_in     (osc_tick),
    .clear_in    (wdt_restart_in | sys_evt),
    .run_in      (mode != WDTRF_STOP),
    .select_in   (ps_r),
    .timeout_out (timeout)
  );

  // apb decode; zero wait states, write lands at the access edge
  assign setup    = psel_in & ~penable_in;
  assign acc      = psel_in & penable_in & pready_out;
  assign wr       = acc & pwrite_in & pstrb_in[0];
  assign wr_ctrl  = wr && (paddr_in == CTRL_OFFSET);
  assign wr_cause = wr && (paddr_in == CAUSE_OFFSET);

  // read images
  assign ctrl_rd  = {irq_flag_r, ie_eff, ps_r[3], ce_r, wde_eff, ps_r[2:0]};
  assign cause_rd = {4'h0, watchdog_reset_flag_r, brownout_reset_flag_r, external_reset_flag_r, poweron_reset_flag_r};

  // apb answer registers, loaded in the setup cycle
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup && (paddr_in != CTRL_OFFSET) && (paddr_in != CAUSE_OFFSET);
      if (setup)
      begin
        if (paddr_in == CTRL_OFFSET)
          prdata_out <= {24'h00_0000, ctrl_rd};
        else if (paddr_in == CAUSE_OFFSET)
          prdata_out <= {24'h00_0000, cause_rd};
        else
          prdata_out <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // irq flag: time-out set beats ack or write-one clear
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_flag_r <= 1'b0;
    else if (sys_evt)
      irq_flag_r <= 1'b0;
    else if (set_flag)
      irq_flag_r <= 1'b1;
    else if (irq_ack_in || (wr_ctrl && pwdata_in[CTRL_FLAG_BIT]))
      irq_flag_r <= 1'b0;
  end

  // irq enable: software write wins over the handler clear
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_en_r <= 1'b0;
    else if (sys_evt)
      irq_en_r <= 1'b0;
    else if (wr_ctrl)
      irq_en_r <= pwdata_in[CTRL_IE_BIT];
    else if (irq_ack_in && (mode == WDTRF_BOTH))
      irq_en_r <= 1'b0;
  end

  // change enable: open for exactly four cycles after a one is written
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ce_r     <= 1'b0;
      ce_cnt_r <= 2'h0;
    end
    else if (sys_evt)
    begin
      ce_r     <= 1'b0;
      ce_cnt_r <= 2'h0;
    end
    else if (wr_ctrl)
    begin
      ce_r     <= pwdata_in[CTRL_CE_BIT];
      ce_cnt_r <= 2'h0;
    end
    else if (ce_r && (ce_cnt_r == CE_LAST))
      ce_r <= 1'b0;
    else if (ce_r)
      ce_cnt_r <= ce_cnt_r + 2'h1;
  end

  // reset enable: setting always allowed, clearing only in the window
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      wde_r <= 1'b0;
    else if (sys_evt)
      wde_r <= 1'b0;
    else if (wr_ctrl && (pwdata_in[CTRL_WDE_BIT] || (ce_r && !watchdog_reset_flag_r)))
      wde_r <= pwdata_in[CTRL_WDE_BIT];
  end

  // prescale select: only changes inside the window
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ps_r <= 4'h0;
    else if (sys_evt)
      ps_r <= 4'h0;
    else if (wr_ctrl && ce_r)
      ps_r <= {pwdata_in[CTRL_PS3_BIT], pwdata_in[CTRL_PSLO_MSB:0]};
  end

  // one-cycle reset pulse and registered irq request
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sys_reset_out <= 1'b0;
      irq_out       <= 1'b0;
    end
    else
    begin
      sys_reset_out <= wdt_fire & ~sys_reset_out;
      irq_out       <= irq_flag_r & ie_eff & global_irq_enable_in;
    end
  end

  // cause flags survive every reset but power-on; hardware set wins
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      watchdog_reset_flag_r  <= 1'b0;
      brownout_reset_flag_r  <= 1'b0;
      external_reset_flag_r <= 1'b0;
      poweron_reset_flag_r  <= 1'b1;
    end
    else
    begin
      if (sys_reset_out)
        watchdog_reset_flag_r <= 1'b1;
      else if (wr_cause && !pwdata_in[CAUSE_WD_BIT])
        watchdog_reset_flag_r <= 1'b0;
      if (bo_evt)
        brownout_reset_flag_r <= 1'b1;
      else if (wr_cause && !pwdata_in[CAUSE_BO_BIT])
        brownout_reset_flag_r <= 1'b0;
      if (ext_evt)
        external_reset_flag_r <= 1'b1;
      else if (wr_cause && !pwdata_in[CAUSE_EXT_BIT])
        external_reset_flag_r <= 1'b0;
      if (wr_cause && !pwdata_in[CAUSE_POR_BIT])
        poweron_reset_flag_r <= 1'b0;
    end
  end

  // checks
  property p_cause_rsvd_zero;
    @(posedge clock_in) disable iff (sys_rst_in)
      (acc && paddr_in == CAUSE_OFFSET) |-> (prdata_out[31:4] == 28'h0);
  endproperty
  a_cause_rsvd_zero: assert property (p_cause_rsvd_zero) else $error("reserved bits not zero");

  property p_wd_flag_set;
    @(posedge clock_in) disable iff (sys_rst_in)
      sys_reset_out |=> watchdog_reset_flag_r;
  endproperty
  a_wd_flag_set: assert property (p_wd_flag_set) else $error("watchdog flag not set");

  property p_bo_flag_set;
    @(posedge clock_in) disable iff (sys_rst_in)
      bo_evt |=> brownout_reset_flag_r;
  endproperty
  a_bo_flag_set: assert property (p_bo_flag_set) else $error("brown-out flag not set");

  property p_ext_flag_set;
    @(posedge clock_in) disable iff (sys_rst_in)
      ext_evt |=> external_reset_flag_r;
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set) else $error("external flag not set");

  property p_por_clear_only_write;
    @(posedge clock_in) disable iff (sys_rst_in)
      $fell(poweron_reset_flag_r) |-> $past(wr_cause) && !$past(pwdata_in[CAUSE_POR_BIT]);
  endproperty
  a_por_clear_only_write: assert property (p_por_clear_only_write)
    else $error("power-on flag cleared without write");

  property p_irq_gate;
    @(posedge clock_in) disable iff (sys_rst_in)
      irq_out |-> $past(irq_flag_r) && $past(ie_eff) && $past(global_irq_enable_in);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq raised without all enables");

  property p_fuse_forces_reset;
    @(posedge clock_in) disable iff (sys_rst_in)
      fuse_prog |-> (mode == WDTRF_RST) && ctrl_rd[CTRL_WDE_BIT] && !ctrl_rd[CTRL_IE_BIT];
  endproperty
  a_fuse_forces_reset: assert property (p_fuse_forces_reset) else $error("fuse override lost");

  property p_ce_window;
    @(posedge clock_in) disable iff (sys_rst_in)
      (wr_ctrl && pwdata_in[CTRL_CE_BIT] && !sys_evt) ##1 (!wr_ctrl && !sys_evt) [*4]
        |=> !ce_r;
  endproperty
  a_ce_window: assert property (p_ce_window) else $error("change enable outlived window");

  property p_watchdog_reset_flag_holds_wde;
    @(posedge clock_in) disable iff (sys_rst_in)
      watchdog_reset_flag_r |-> ctrl_rd[CTRL_WDE_BIT];
  endproperty
  a_watchdog_reset_flag_holds_wde: assert property (p_watchdog_reset_flag_holds_wde) else $error("reset enable readable low");

  property p_reset_pulse_one;
    @(posedge clock_in) disable iff (sys_rst_in)
      sys_reset_out |=> !sys_reset_out ##1 !irq_flag_r;
  endproperty
  a_reset_pulse_one: assert property (p_reset_pulse_one) else $error("reset pulse too long");

endmodule : wdtrf_top

// ---- pkg/wdtrf_pkg.sv ----
package wdtrf_pkg;

  // apb map, byte addresses
  localparam int unsigned APB_AW       = 12;
  localparam logic [11:0] CTRL_OFFSET  = 12'h060;
  localparam logic [11:0] CAUSE_OFFSET = 12'h064;

  // control register fields
  localparam int unsigned CTRL_FLAG_BIT = 7;
  localparam int unsigned CTRL_IE_BIT   = 6;
  localparam int unsigned CTRL_PS3_BIT  = 5;
  localparam int unsigned CTRL_CE_BIT   = 4;
  localparam int unsigned CTRL_WDE_BIT  = 3;
  localparam int unsigned CTRL_PSLO_MSB = 2;

  // reset cause fields
  localparam int unsigned CAUSE_WD_BIT  = 3;
  localparam int unsigned CAUSE_BO_BIT  = 2;
  localparam int unsigned CAUSE_EXT_BIT = 1;
  localparam int unsigned CAUSE_POR_BIT = 0;

  // change enable window in core cycles
  localparam int unsigned CE_WINDOW_CYCLES = 4;
  localparam logic [1:0]  CE_LAST          = 2'(CE_WINDOW_CYCLES - 1);

  // time-out base in oscillator cycles, largest legal code
  localparam int unsigned WDT_BASE_CYCLES = 2048;
  localparam logic [3:0]  PS_MAX_CODE     = 4'h9;
  localparam int unsigned WDT_CNT_W       = 21;

  // synchroniser lanes and their idle levels (fuse idles unprogrammed)
  localparam int unsigned SYNC_OSC  = 0;
  localparam int unsigned SYNC_BO   = 1;
  localparam int unsigned SYNC_EXT  = 2;
  localparam int unsigned SYNC_FUSE = 3;
  localparam int unsigned SYNC_W    = 4;
  localparam logic [3:0]  SYNC_INIT = 4'h8;

  // watchdog operating modes
  typedef enum logic [3:0] {
    WDTRF_STOP = 4'b0001,
    WDTRF_IRQ  = 4'b0010,
    WDTRF_RST  = 4'b0100,
    WDTRF_BOTH = 4'b1000
  } wdtrf_mode_t;

  // mode from fuse (1 = programmed) and the two enables
  function automatic wdtrf_mode_t wdtrf_decode_mode(input logic fuse_prog,
                                                    input logic system_reset_enable,
                                                    input logic ie);
    wdtrf_mode_t m;
    if (fuse_prog)
      m = WDTRF_RST;
    else
      m = system_reset_enable ? (ie ? WDTRF_BOTH : WDTRF_RST) : (ie ? WDTRF_IRQ : WDTRF_STOP);
    return m;
  endfunction : wdtrf_decode_mode

endpackage : wdtrf_pkg

// ---- test/wdtrf_tb_top.sv ----
`timescale 1ns/10ps
module wdtrf_tb_top
  import wdtrf_pkg::*;
;
  localparam int BASE  = 4;      // short time-out base keeps the run brief
  localparam int LIMIT = 20000;  // hang ceiling in core cycles
  // clock, reset and apb
  logic        clock_in   = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [11:0] paddr_in   = 12'h000;
  logic [31:0] pwdata_in  = 32'h00000000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  // pins and core side
  logic        brownout_rst_in      = 1'b0;
  logic        external_rst_in      = 1'b0;
  logic        always_on_fuse_in    = 1'b1;
  logic        global_irq_enable_in = 1'b1;
  logic        irq_ack_in           = 1'b0;
  logic        wdt_restart_in       = 1'b1;  // held high keeps the counter at zero
  logic        irq_out;
  logic        sys_reset_out;
  // oscillator made from core cycles so time-outs have a fixed phase
  logic [2:0]  osc_div = 3'h0;
  int          err_total = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          t0;
  int          t1;

  wdtrf_top #(.TIMEOUT_BASE_CYCLES(BASE)) u_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(4'hF), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .wdt_osc_in(osc_div[2]),
    .brownout_rst_in(brownout_rst_in), .external_rst_in(external_rst_in),
    .always_on_fuse_in(always_on_fuse_in), .global_irq_enable_in(global_irq_enable_in),
    .irq_ack_in(irq_ack_in), .wdt_restart_in(wdt_restart_in), .irq_out(irq_out),
    .sys_reset_out(sys_reset_out));

  // 8 ns core clock
  initial
  begin
    forever #4 clock_in = ~clock_in;
  end

  // oscillator period is 8 core cycles, well below half the core rate
  always @(posedge clock_in)
  begin
    osc_div <= osc_div + 3'h1;
    cyc     <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle

  // one apb transfer; answer sampled at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= {24'h000000, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1)
      @(posedge clock_in);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // read, compare the whole word and the error response
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic eexp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    chk_word(q, {24'h000000, exp});
    chk_flag(e, eexp);
  endtask : rd

  // change window opened, then the protected write right behind it
  task automatic timed(input logic [7:0] d);
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, d);
  endtask : timed

  // release restart on a fixed oscillator phase, count cycles to irq or reset
  task automatic run_out(input bit rst, input int max, input bit keep, output int n);
    while (osc_div !== 3'h0)
      @(posedge clock_in);
    wdt_restart_in <= 1'b0;
    n = -1;
    for (int i = 1; i <= max && n < 0; i++)
    begin
      @(posedge clock_in);
      if ((rst ? sys_reset_out : irq_out) === 1'b1)
        n = i;
    end
    if (!keep)
      wdt_restart_in <= 1'b1;
  endtask : run_out

  task automatic t_regs();
    rd(CTRL_OFFSET, 8'h00, 1'b0);
    rd(CAUSE_OFFSET, 8'h01, 1'b0);
    rd(12'h068, 8'h00, 1'b1);       // unmapped word answers with an error
    wr(CAUSE_OFFSET, 8'hFF);
    rd(CAUSE_OFFSET, 8'h01, 1'b0);
    wr(CAUSE_OFFSET, 8'h00);
    rd(CAUSE_OFFSET, 8'h00, 1'b0);
  endtask : t_regs

  // pin events set their flags, a power-on reset clears them again
  task automatic t_events();
    wr(CTRL_OFFSET, 8'h40);
    external_rst_in <= 1'b1;
    idle(3);
    external_rst_in <= 1'b0;
    rd(CAUSE_OFFSET, 8'h02, 1'b0);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
    brownout_rst_in <= 1'b1;
    idle(3);
    brownout_rst_in <= 1'b0;
    rd(CAUSE_OFFSET, 8'h06, 1'b0);
    sys_rst_in <= 1'b1;
    idle(2);
    sys_rst_in <= 1'b0;
    rd(CAUSE_OFFSET, 8'h01, 1'b0);
    wr(CAUSE_OFFSET, 8'h00);
  endtask : t_events

  // interrupt mode: flag, gating, clearing and two time-out lengths
  task automatic t_irq();
    int n;
    wr(CTRL_OFFSET, 8'h40);
    run_out(1'b0, 100, 1'b0, t0);
    chk_flag(1'(t0 >= 24 && t0 <= 40), 1'b1);
    rd(CTRL_OFFSET, 8'hC0, 1'b0);
    global_irq_enable_in <= 1'b0;
    idle(3);
    chk_flag(irq_out, 1'b0);
    global_irq_enable_in <= 1'b1;
    idle(3);
    chk_flag(irq_out, 1'b1);
    wr(CTRL_OFFSET, 8'hC0);
    rd(CTRL_OFFSET, 8'h40, 1'b0);
    timed(8'h41);
    rd(CTRL_OFFSET, 8'h41, 1'b0);
    run_out(1'b0, 100, 1'b0, t1);
    chk_word(32'(t1 - t0), 32'h00000020);
    irq_ack_in <= 1'b1;
    idle(1);
    irq_ack_in <= 1'b0;
    rd(CTRL_OFFSET, 8'h41, 1'b0);
    timed(8'h00);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
    run_out(1'b0, 150, 1'b1, n);
    chk_flag(1'(n < 0), 1'b1);
    run_out(1'b1, 60, 1'b0, n);
    chk_flag(1'(n < 0), 1'b1);
  endtask : t_irq

  // restart part way through a period puts the time-out a full period after the restart
  task automatic t_restart();
    int n;
    wr(CTRL_OFFSET, 8'h40);
    run_out(1'b0, 20, 1'b1, n);
    chk_flag(1'(n < 0), 1'b1);
    wdt_restart_in <= 1'b1;
    idle(1);
    wdt_restart_in <= 1'b0;
    n = -1;
    // without the restart the time-out would land a dozen cycles from here
    for (int i = 1; i <= 60 && n < 0; i++)
    begin
      @(posedge clock_in);
      if (irq_out === 1'b1)
        n = i;
    end
    wdt_restart_in <= 1'b1;
    chk_flag(1'(n >= 24 && n <= 40), 1'b1);
    wr(CTRL_OFFSET, 8'h80);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
  endtask : t_restart

  // protected fields, window expiry, reset pulse and its flag
  task automatic t_wde();
    int n;
    wr(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    wr(CTRL_OFFSET, 8'h18);
    rd(CTRL_OFFSET, 8'h18, 1'b0);
    idle(6);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    wr(CTRL_OFFSET, 8'h49);
    rd(CTRL_OFFSET, 8'h48, 1'b0);
    wr(CTRL_OFFSET, 8'h08);
    run_out(1'b1, 100, 1'b0, n);
    chk_flag(1'(n > 0), 1'b1);
    idle(1);
    chk_flag(sys_reset_out, 1'b0);
    rd(CAUSE_OFFSET, 8'h08, 1'b0);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    timed(8'h00);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    wr(CAUSE_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    timed(8'h00);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
  endtask : t_wde

  // combined mode: unserviced time-out resets, serviced one drops to reset mode
  task automatic t_comb();
    int n;
    wr(CTRL_OFFSET, 8'h48);
    run_out(1'b0, 100, 1'b1, n);
    chk_flag(1'(n > 0), 1'b1);
    rd(CTRL_OFFSET, 8'hC8, 1'b0);
    run_out(1'b1, 100, 1'b0, n);
    chk_flag(1'(n > 0), 1'b1);
    wr(CAUSE_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h48);
    run_out(1'b0, 100, 1'b0, n);
    chk_flag(1'(n > 0), 1'b1);
    irq_ack_in <= 1'b1;
    idle(1);
    irq_ack_in <= 1'b0;
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    timed(8'h00);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
  endtask : t_comb

  // programmed fuse pins the enables and forces reset mode
  task automatic t_fuse();
    int n;
    always_on_fuse_in <= 1'b0;
    idle(4);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    wr(CTRL_OFFSET, 8'h40);
    rd(CTRL_OFFSET, 8'h08, 1'b0);
    run_out(1'b1, 100, 1'b0, n);
    chk_flag(1'(n > 0), 1'b1);
    always_on_fuse_in <= 1'b1;
    idle(4);
    wr(CAUSE_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h00, 1'b0);
  endtask : t_fuse

  // main sequence
  initial
  begin
    idle(6);
    sys_rst_in <= 1'b0;
    t_regs();
    t_events();
    t_irq();
    t_restart();
    t_wde();
    t_comb();
    t_fuse();
    results();
  end
endmodule : wdtrf_tb_top
